// ### pkg/awg_pkg.sv
// package: register map, fields, resets and timing of the aux bank
package awg_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_EXT_CTRL    = 10'h100;
  localparam logic [9:0] IDX_SLEEP_CFG   = 10'h317;
  localparam logic [9:0] IDX_TIMER_CTRL  = 10'h31A;
  localparam logic [9:0] IDX_WAKE_STATUS = 10'h31B;
  localparam logic [9:0] IDX_AUX_POWER   = 10'h31E;
  localparam logic [9:0] IDX_PIN_FUNC    = 10'h32C;
  localparam logic [9:0] IDX_PIN_OUT     = 10'h32D;
  localparam logic [9:0] IDX_FILTER_CAL  = 10'h33D;
  localparam logic [9:0] IDX_OSC_BAND    = 10'h353;
  localparam logic [9:0] IDX_OSC_CURR    = 10'h354;
  localparam logic [9:0] IDX_OSC_OVR_EN  = 10'h355;
  localparam logic [9:0] IDX_OSC_CAL_CFG = 10'h36F;
  // status bit positions
  localparam int unsigned ST_CAL_DONE = 5;
  localparam int unsigned ST_XTAL     = 4;
  localparam int unsigned ST_COLD     = 2;
  localparam int unsigned ST_TIMEOUT  = 1;
  // aux power bit positions
  localparam int unsigned AUX_CTL_HI  = 6;
  localparam int unsigned AUX_BATT    = 5;
  localparam int unsigned AUX_PABIAS  = 4;
  // control and override enable bits
  localparam int unsigned TC_FLAG_RST = 0;
  localparam int unsigned TC_CAL_EN   = 1;
  localparam int unsigned EXT_RXEN    = 0;
  localparam int unsigned EXT_TXEN    = 1;
  localparam int unsigned EXT_PA_AUTO = 2;
  localparam int unsigned OVR_BAND    = 0;
  localparam int unsigned OVR_CURR    = 1;
  // pin positions
  localparam int unsigned PIN_RXEN    = 6;
  localparam int unsigned PIN_TXEN    = 5;
  localparam int unsigned PIN_INTERRUPT_OUT_ONE    = 0;
  localparam int unsigned PIN_INTERRUPT_OUT_TWO    = 1;
  localparam int unsigned PIN_SYM3    = 6;
  localparam int unsigned PIN_SYM2    = 5;
  localparam int unsigned PIN_SYM1    = 1;
  localparam int unsigned PIN_SYM0    = 0;
  // pins 6, 5, 1, 0: shared by interrupt and symbol modes
  localparam logic [7:0] OE_SHARED_PINS  = 8'h63;
  // field positions and codes
  localparam int unsigned SLEEP_LSB   = 3;
  localparam logic [3:0] SLEEP_XTO       = 4'h4;
  localparam logic [3:0] SLEEP_BBRAM_XTO = 4'h5;
  localparam logic [3:0] OSC_CAL_NORMAL  = 4'h9;
  localparam logic [3:0] OSC_CAL_SKIP    = 4'hF;
  localparam logic [1:0] FCAL_RUN        = 2'h0;
  localparam logic [1:0] FCAL_SKIP       = 2'h3;
  // reset values
  localparam logic [7:0] RST_FILTER_CAL  = 8'h3C;
  localparam logic [7:0] RST_OSC_OVR_EN  = 8'h08;
  localparam logic [7:0] RST_OSC_CAL_CFG = 8'h09;
  // pin function codes
  typedef enum logic [7:0] {
    PF_IRQ    = 8'h00,
    PF_SPORT  = 8'h01,
    PF_GPIO   = 8'h04,
    PF_SYMBOL = 8'h07
  } awg_pin_mode_type;
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  // timing
  localparam int unsigned CLK_FREQ_MHZ  = 25;
  localparam int unsigned LF_CAL_TIME_US = 1000;
  localparam int unsigned LF_CAL_CYCLES = LF_CAL_TIME_US * CLK_FREQ_MHZ;
endpackage

// ### pkg/awg_flag_if.sv
// interface: one sticky event flag between its owner and the register bank
`timescale 1ns/10ps
interface awg_flag_if;
  logic set;   // event pulse
  logic clear; // clear request level
  logic flag;  // sticky flag
  modport owner (input set, input clear, output flag);
  modport user  (output set, output clear, input flag);
endinterface

// ### hdl/awg_sticky_flag.sv
// module: sticky event flag, set wins over clear
`timescale 1ns/10ps
module awg_sticky_flag (
  // clock and reset
  input wire logic  hclk,
  input wire logic  hresetn,
  // flag link
  awg_flag_if.owner f
);
  typedef struct packed {
    logic flag; // held event
  } awg_flag_state_type;

  awg_flag_state_type s_ff;
  awg_flag_state_type nxt_s;

  // set beats a same-cycle clear, so no event is lost
  always_comb begin
    nxt_s = s_ff;
    if (f.set) begin
      nxt_s.flag = 1'b1;
    end else if (f.clear) begin
      nxt_s.flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign f.flag = s_ff.flag;
endmodule

// ### hdl/awg_cal_timer.sv
// module: low-frequency oscillator calibration run timer
`timescale 1ns/10ps
module awg_cal_timer #(
  parameter int unsigned CYCLES = awg_pkg::LF_CAL_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and result
  input wire logic enable,
  output logic     done
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  // a zero-length run cannot be timed
  generate
    if (CYCLES < 1) begin : g_bad
      $error("calibration cycle count must be at least one");
    end
  endgenerate

  typedef enum logic [1:0] {
    CT_IDLE = 2'b00,
    CT_RUN  = 2'b01,
    CT_DONE = 2'b10
  } awg_cal_state_type;

  typedef struct packed {
    awg_cal_state_type st;  // run phase
    logic [CW-1:0]     cnt; // elapsed cycles
    logic              done;
  } awg_cal_type;

  awg_cal_type s_ff;
  awg_cal_type nxt_s;

  // run on enable, done after the fixed time; dropping enable aborts
  always_comb begin
    nxt_s = s_ff;
    case (s_ff.st)
      CT_IDLE: begin
        nxt_s.cnt  = '0;
        nxt_s.done = 1'b0;
        if (enable) begin
          nxt_s.st = CT_RUN;
        end
      end
      CT_RUN: begin
        if (!enable) begin
          nxt_s.st = CT_IDLE;
        end else if (s_ff.cnt == CW'(CYCLES - 1)) begin
          nxt_s.st   = CT_DONE;
          nxt_s.done = 1'b1;
        end else begin
          nxt_s.cnt = s_ff.cnt + CW'(1);
        end
      end
      CT_DONE: begin
        // result only holds while enable stays set
        if (!enable) begin
          nxt_s.st   = CT_IDLE;
          nxt_s.done = 1'b0;
        end
      end
      default: begin
        nxt_s.st = CT_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '{st: CT_IDLE, cnt: '0, done: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
endmodule

// ### hdl/awg_aux_regs.sv
// module: auxiliary wake-up, pin function and calibration register bank on AHB-Lite
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
//
// Contract
// - calibration done 1 ms after start
// - status bit 5: calibration finished
// - status bit 4: crystal settled
// - status bit 2: cold start
// - status bit 1: timeout latch
// - flag reset clears both flags
// - aux bit 5: battery monitor
// - aux bit 4: external PA bias
// - auto mode: controller drives PA bias
// - aux bits 6, 3:0 controller owned
// - mode 0: interrupts, rx/tx enable pins
// - mode 1: rx serial pins after sync
// - modes 1, 4: tx serial pins
// - mode 7: symbol clock and data
// - mode 4: output bits drive pins
// - rx automation owns output bit 6
// - tx automation owns output bit 5
// - filter cal on idle-to-ready unless skipped
// - band override: enable and skip 15
// - current override: enable and skip 15
// - enable bits: 1 current, 0 band
// - skip field: 9 normal, 15 skip
module awg_aux_regs #(
  parameter int unsigned LF_CAL_CYCLES = awg_pkg::LF_CAL_CYCLES
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  output logic            hreadyout,
  output logic            hresp,
  output logic [31:0]     hrdata,
  // radio controller side
  input wire logic        rc_extpa_bias_en,
  input wire logic        rc_aux_hi,
  input wire logic [3:0]  rc_aux_lo,
  input wire logic        rc_rxen,
  input wire logic        rc_txen,
  input wire logic        rx_active,
  input wire logic        tx_active,
  input wire logic        sync_word_detected,
  input wire logic        phy_ready_entry,
  input wire logic        sport_clk_in,
  input wire logic        sport_data_in,
  input wire logic        symbol_clk_in,
  input wire logic [3:0]  symbol_data_in,
  input wire logic        interrupt_out_one_req,
  input wire logic        interrupt_out_two_req,
  // wake-up controller events
  input wire logic        timer_timeout,
  input wire logic        cold_start,
  input wire logic        slow_crystal_settled,
  // pins
  output logic [7:0]      gpio_out,
  output logic [7:0]      gpio_oe,
  output logic            serial_port_clock_pin,
  output logic            serial_port_clock_oe,
  output logic            serial_port_data_pin,
  output logic            serial_port_data_oe,
  // analog controls
  output logic            battery_monitor_en,
  output logic            extpa_bias_en,
  output logic            lf_calibration_request,
  output logic            filter_cal_start,
  output logic [7:0]      osc_band_value,
  output logic            osc_band_apply,
  output logic [7:0]      osc_current_value,
  output logic            osc_current_apply
);
  // whole state of the bank
  typedef struct packed {
    logic [7:0]  ext_ctrl;    // automation enables
    logic [7:0]  sleep_cfg;   // sleep setting
    logic [7:0]  timer_ctrl;  // flag reset and calibration enable
    logic [7:0]  aux_sw;      // software part of aux power
    logic [7:0]  pin_func;    // pin function select
    logic [7:0]  pin_out;     // software pin values
    logic [7:0]  filter_cal;  // filter calibration setup
    logic [7:0]  osc_band;    // band override value
    logic [7:0]  osc_curr;    // current override value
    logic [7:0]  osc_ovr_en;  // override enables
    logic [7:0]  osc_cal_cfg; // oscillator calibration skip
    logic        dph_valid;   // data phase pending
    logic        dph_write;   // data phase is a write
    logic [9:0]  dph_idx;     // data phase register index
    logic        hready;
    logic [31:0] hrdata;
    logic [7:0]  gpio_out;
    logic [7:0]  gpio_oe;
    logic        sp_clk;
    logic        sp_clk_oe;
    logic        sp_data;
    logic        sp_data_oe;
    logic        batt_en;
    logic        pa_bias_en;
    logic        fcal_start;
    logic        band_apply;
    logic        curr_apply;
  } awg_bank_type;

  // fields not named here reset to zero
  localparam awg_bank_type RST_STATE = '{
    filter_cal:  awg_pkg::RST_FILTER_CAL,
    osc_ovr_en:  awg_pkg::RST_OSC_OVR_EN,
    osc_cal_cfg: awg_pkg::RST_OSC_CAL_CFG,
    hready:      1'b1,
    default:     '0
  };

  awg_bank_type s_ff;
  awg_bank_type nxt_s;

  // flag links
  awg_flag_if cold_if ();
  awg_flag_if tmo_if ();
  logic       cal_done; // calibration timer result

  // cold start registration
  awg_sticky_flag u_cold_flag (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (cold_if.owner)
  );

  // timeout latch
  awg_sticky_flag u_tmo_flag (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (tmo_if.owner)
  );

  // calibration run timer
  awg_cal_timer #(
    .CYCLES (LF_CAL_CYCLES)
  ) u_cal_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (s_ff.timer_ctrl[awg_pkg::TC_CAL_EN]),
    .done    (cal_done)
  );

  // flag events; reset level from the timer control bit, event wins
  assign cold_if.set   = cold_start;
  assign tmo_if.set    = timer_timeout;
  assign cold_if.clear = s_ff.timer_ctrl[awg_pkg::TC_FLAG_RST];
  assign tmo_if.clear  = s_ff.timer_ctrl[awg_pkg::TC_FLAG_RST];

  // combinational helpers
  logic       addr_take;  // valid address phase
  logic       mapped;     // upper address bits clear
  logic [9:0] a_idx;      // address phase index
  logic [7:0] pin_eff;    // pin values after automation
  logic [7:0] aux_eff;    // aux power as seen by hardware
  logic [7:0] status;     // live wake status
  logic [7:0] rd_byte;    // selected read value
  logic [3:0] sleep_sel;  // sleep setting field
  logic       osc_skip;   // oscillator calibration skipped
  logic       sp_active;  // serial port pins active

  // writes land first, so a read right after sees the new value
  always_comb begin
    nxt_s     = s_ff;
    addr_take = hsel && hready && htrans[1];
    mapped    = (haddr[31:12] == 20'h00000);
    a_idx     = haddr[11:2];
    // data phase write; low byte holds the register
    if (s_ff.dph_valid && s_ff.dph_write) begin
      if (s_ff.dph_idx == awg_pkg::IDX_EXT_CTRL) begin
        nxt_s.ext_ctrl = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_SLEEP_CFG) begin
        nxt_s.sleep_cfg = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_TIMER_CTRL) begin
        nxt_s.timer_ctrl = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_AUX_POWER) begin
        nxt_s.aux_sw = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_PIN_FUNC) begin
        nxt_s.pin_func = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_PIN_OUT) begin
        nxt_s.pin_out = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_FILTER_CAL) begin
        nxt_s.filter_cal = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_OSC_BAND) begin
        nxt_s.osc_band = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_OSC_CURR) begin
        nxt_s.osc_curr = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_OSC_OVR_EN) begin
        nxt_s.osc_ovr_en = hwdata[7:0];
      end else if (s_ff.dph_idx == awg_pkg::IDX_OSC_CAL_CFG) begin
        nxt_s.osc_cal_cfg = hwdata[7:0];
      end
    end

    // automation takes pin bits 6, 5 from the controller
    pin_eff = nxt_s.pin_out;
    if (nxt_s.ext_ctrl[awg_pkg::EXT_RXEN]) begin
      pin_eff[awg_pkg::PIN_RXEN] = rc_rxen;
    end
    if (nxt_s.ext_ctrl[awg_pkg::EXT_TXEN]) begin
      pin_eff[awg_pkg::PIN_TXEN] = rc_txen;
    end

    // controller bits from controller; PA bias when auto
    aux_eff = nxt_s.aux_sw;
    aux_eff[awg_pkg::AUX_CTL_HI] = rc_aux_hi;
    aux_eff[3:0] = rc_aux_lo;
    if (nxt_s.ext_ctrl[awg_pkg::EXT_PA_AUTO]) begin
      aux_eff[awg_pkg::AUX_PABIAS] = rc_extpa_bias_en;
    end

    // live status; a read only samples, nothing here clears
    sleep_sel = s_ff.sleep_cfg[awg_pkg::SLEEP_LSB +: 4];
    status    = 8'h00;
    status[awg_pkg::ST_CAL_DONE] = cal_done;
    status[awg_pkg::ST_XTAL] = slow_crystal_settled &&
      (sleep_sel == awg_pkg::SLEEP_XTO || sleep_sel == awg_pkg::SLEEP_BBRAM_XTO);
    status[awg_pkg::ST_COLD]    = cold_if.flag;
    status[awg_pkg::ST_TIMEOUT] = tmo_if.flag;

    // read mux on the address phase index, unmapped reads zero
    rd_byte = 8'h00;
    if (!mapped) begin
      rd_byte = 8'h00;
    end else if (a_idx == awg_pkg::IDX_EXT_CTRL) begin
      rd_byte = nxt_s.ext_ctrl;
    end else if (a_idx == awg_pkg::IDX_SLEEP_CFG) begin
      rd_byte = nxt_s.sleep_cfg;
    end else if (a_idx == awg_pkg::IDX_TIMER_CTRL) begin
      rd_byte = nxt_s.timer_ctrl;
    end else if (a_idx == awg_pkg::IDX_WAKE_STATUS) begin
      rd_byte = status;
    end else if (a_idx == awg_pkg::IDX_AUX_POWER) begin
      rd_byte = aux_eff;
    end else if (a_idx == awg_pkg::IDX_PIN_FUNC) begin
      rd_byte = nxt_s.pin_func;
    end else if (a_idx == awg_pkg::IDX_PIN_OUT) begin
      rd_byte = pin_eff;
    end else if (a_idx == awg_pkg::IDX_FILTER_CAL) begin
      rd_byte = nxt_s.filter_cal;
    end else if (a_idx == awg_pkg::IDX_OSC_BAND) begin
      rd_byte = nxt_s.osc_band;
    end else if (a_idx == awg_pkg::IDX_OSC_CURR) begin
      rd_byte = nxt_s.osc_curr;
    end else if (a_idx == awg_pkg::IDX_OSC_OVR_EN) begin
      rd_byte = nxt_s.osc_ovr_en;
    end else if (a_idx == awg_pkg::IDX_OSC_CAL_CFG) begin
      rd_byte = nxt_s.osc_cal_cfg;
    end

    // bus pipeline; zero wait states, always OKAY
    nxt_s.hready    = 1'b1;
    nxt_s.dph_valid = addr_take && mapped;
    nxt_s.dph_write = hwrite;
    nxt_s.dph_idx   = a_idx;
    if (addr_take && !hwrite) begin
      nxt_s.hrdata = {24'h000000, rd_byte};
    end

    // pin function decode; reserved codes leave every pin undriven
    sp_active       = (rx_active && sync_word_detected) || tx_active;
    nxt_s.gpio_out  = 8'h00;
    nxt_s.gpio_oe   = 8'h00;
    nxt_s.sp_clk    = 1'b0;
    nxt_s.sp_clk_oe = 1'b0;
    nxt_s.sp_data   = 1'b0;
    nxt_s.sp_data_oe = 1'b0;
    case (awg_pkg::awg_pin_mode_type'(nxt_s.pin_func))
      awg_pkg::PF_IRQ: begin
        nxt_s.gpio_out[awg_pkg::PIN_INTERRUPT_OUT_ONE] = interrupt_out_one_req;
        nxt_s.gpio_out[awg_pkg::PIN_INTERRUPT_OUT_TWO] = interrupt_out_two_req;
        nxt_s.gpio_out[awg_pkg::PIN_RXEN] = pin_eff[awg_pkg::PIN_RXEN];
        nxt_s.gpio_out[awg_pkg::PIN_TXEN] = pin_eff[awg_pkg::PIN_TXEN];
        nxt_s.gpio_oe = awg_pkg::OE_SHARED_PINS;
      end
      awg_pkg::PF_SPORT: begin
        // receive side waits for sync so noise never clocks out
        nxt_s.sp_clk     = sp_active && sport_clk_in;
        nxt_s.sp_data    = sp_active && sport_data_in;
        nxt_s.sp_clk_oe  = sp_active;
        nxt_s.sp_data_oe = sp_active;
      end
      awg_pkg::PF_GPIO: begin
        nxt_s.gpio_out   = pin_eff;
        nxt_s.gpio_oe    = 8'hFF;
        nxt_s.sp_clk     = tx_active && sport_clk_in;
        nxt_s.sp_data    = tx_active && sport_data_in;
        nxt_s.sp_clk_oe  = tx_active;
        nxt_s.sp_data_oe = tx_active;
      end
      awg_pkg::PF_SYMBOL: begin
        nxt_s.sp_clk    = symbol_clk_in;
        nxt_s.sp_clk_oe = 1'b1;
        nxt_s.gpio_out[awg_pkg::PIN_SYM3] = symbol_data_in[3];
        nxt_s.gpio_out[awg_pkg::PIN_SYM2] = symbol_data_in[2];
        nxt_s.gpio_out[awg_pkg::PIN_SYM1] = symbol_data_in[1];
        nxt_s.gpio_out[awg_pkg::PIN_SYM0] = symbol_data_in[0];
        nxt_s.gpio_oe = awg_pkg::OE_SHARED_PINS;
      end
      default: begin
        // reserved codes: software must not use them
        nxt_s.gpio_oe = 8'h00;
      end
    endcase

    // analog enables follow the effective aux power bits
    nxt_s.batt_en    = aux_eff[awg_pkg::AUX_BATT];
    nxt_s.pa_bias_en = aux_eff[awg_pkg::AUX_PABIAS];

    // filter calibration on idle to ready; nonzero code skips
    nxt_s.fcal_start = phy_ready_entry &&
      (nxt_s.filter_cal[1:0] == awg_pkg::FCAL_RUN);

    // overrides apply only with calibration skipped
    osc_skip = (nxt_s.osc_cal_cfg[3:0] == awg_pkg::OSC_CAL_SKIP);
    nxt_s.band_apply = osc_skip && nxt_s.osc_ovr_en[awg_pkg::OVR_BAND];
    nxt_s.curr_apply = osc_skip && nxt_s.osc_ovr_en[awg_pkg::OVR_CURR];
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= RST_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flops, except hresp tied low
  assign hreadyout = s_ff.hready;
  assign hresp = 1'b0;
  assign hrdata = s_ff.hrdata;
  assign gpio_out = s_ff.gpio_out;
  assign gpio_oe = s_ff.gpio_oe;
  assign serial_port_clock_pin = s_ff.sp_clk;
  assign serial_port_clock_oe = s_ff.sp_clk_oe;
  assign serial_port_data_pin = s_ff.sp_data;
  assign serial_port_data_oe = s_ff.sp_data_oe;
  assign battery_monitor_en = s_ff.batt_en;
  assign extpa_bias_en = s_ff.pa_bias_en;
  assign lf_calibration_request = s_ff.timer_ctrl[awg_pkg::TC_CAL_EN];
  assign filter_cal_start = s_ff.fcal_start;
  assign osc_band_value = s_ff.osc_band;
  assign osc_band_apply = s_ff.band_apply;
  assign osc_current_value = s_ff.osc_curr;
  assign osc_current_apply = s_ff.curr_apply;

  // hsize unused: whole words only
  logic unused_hsize;
  assign unused_hsize = ^hsize;
endmodule

// ### verification/awg_aux_sva.sv
// checker: assertions on the aux bank ports
`timescale 1ns/10ps
module awg_aux_sva (
  // clock, reset and bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  // controller, pins and analog controls
  input wire logic        rc_extpa_bias_en, phy_ready_entry, battery_monitor_en,
  input wire logic        extpa_bias_en, filter_cal_start, osc_band_apply,
  input wire logic [7:0]  gpio_oe
);
  logic       wr_ff, rd_ff;                        // data phase of a mapped write / a read
  logic [9:0] idx_ff;                              // index from the address phase
  logic [7:0] ext_ff, aux_ff, pf_ff, fcal_ff, ovr_ff, vcal_ff; // software copies
  // copies of what software wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_ff, rd_ff, idx_ff, ext_ff, aux_ff, pf_ff} <= '0;
      {fcal_ff, ovr_ff, vcal_ff} <= 24'h3C0809;
    end else begin
      wr_ff  <= hsel && hready && htrans[1] && hwrite && haddr[31:12] == 20'h0;
      rd_ff  <= hsel && hready && htrans[1] && !hwrite;
      idx_ff <= haddr[11:2];
      if (wr_ff) begin
        case (idx_ff)
          awg_pkg::IDX_EXT_CTRL:    ext_ff  <= hwdata[7:0];
          awg_pkg::IDX_AUX_POWER:   aux_ff  <= hwdata[7:0];
          awg_pkg::IDX_PIN_FUNC:    pf_ff   <= hwdata[7:0];
          awg_pkg::IDX_FILTER_CAL:  fcal_ff <= hwdata[7:0];
          awg_pkg::IDX_OSC_OVR_EN:  ovr_ff  <= hwdata[7:0];
          awg_pkg::IDX_OSC_CAL_CFG: vcal_ff <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read_data; rd_ff; endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_read_upper: assert property (s_read_data |-> hrdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  a_batt_follow: assert property (battery_monitor_en == aux_ff[5])
    else $error("battery enable wrong");
  a_pa_source: assert property (extpa_bias_en ==
    (ext_ff[2] ? $past(rc_extpa_bias_en) : aux_ff[4])) else $error("pa bias wrong");
  a_gpio_drive: assert property (pf_ff == 8'h04 |-> gpio_oe == 8'hFF)
    else $error("gpio mode enables wrong");
  a_irq_pins: assert property (pf_ff == 8'h00 ##1 pf_ff == 8'h00 |-> gpio_oe == 8'h63)
    else $error("irq mode enables wrong");
  a_band_apply: assert property (osc_band_apply == (vcal_ff[3:0] == 4'hF && ovr_ff[0]))
    else $error("band apply wrong");
  a_fcal_pulse: assert property (filter_cal_start ==
    ($past(phy_ready_entry) && fcal_ff[1:0] == 2'h0)) else $error("filter cal start wrong");
endmodule

// ### verification/awg_aux_regs_tb.sv
// testbench: register bank scenarios over ahb-lite
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module awg_aux_regs_tb;
  logic        hclk = 1'b0, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rc_extpa_bias_en, rc_aux_hi, rc_rxen, rc_txen, rx_active, tx_active;
  logic        sync_word_detected, phy_ready_entry, sport_clk_in, sport_data_in;
  logic        symbol_clk_in, interrupt_out_one_req, interrupt_out_two_req, timer_timeout;
  logic        cold_start, slow_crystal_settled, serial_port_clock_pin, serial_port_clock_oe;
  logic        serial_port_data_pin, serial_port_data_oe, battery_monitor_en, extpa_bias_en;
  logic        lf_calibration_request, filter_cal_start, osc_band_apply, osc_current_apply;
  logic [3:0]  rc_aux_lo, symbol_data_in;
  logic [7:0]  gpio_out, gpio_oe, osc_band_value, osc_current_value, v; // v: last read
  int          err_count = 0, n_tests = 0;
  assign hready = hreadyout; // one slave: its ready is the bus ready
  always #20 hclk = ~hclk;   // 25 mhz
  // short calibration run
  awg_aux_regs #(.LF_CAL_CYCLES(20)) awg_aux_regs_i (.*);
  // single transfer; each phase held until hready high
  task automatic xfer(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge hclk);
    htrans <= awg_pkg::HTRANS_NONSEQ;
    haddr  <= {20'h0, ix, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    v = hrdata[7:0];
  endtask
  task automatic rchk(input logic [9:0] ix, input logic [7:0] ex);
    xfer(1'b0, ix, 8'h00);
    `CHK("register", ex, v)
  endtask
  // let registered outputs settle
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog; tests take under a thousand cycles
  initial begin
    repeat (3000) @(posedge hclk);
    err_count++;
    conclude;
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, rc_extpa_bias_en, rc_aux_hi, rc_aux_lo,
     rc_rxen, rc_txen, rx_active, tx_active, sync_word_detected, phy_ready_entry,
     sport_clk_in, sport_data_in, symbol_clk_in, symbol_data_in, interrupt_out_one_req,
     interrupt_out_two_req, timer_timeout, cold_start, slow_crystal_settled} = '0;
    hsize = awg_pkg::HSIZE_WORD;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    // reset values, one unmapped index
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h00);
    rchk(awg_pkg::IDX_FILTER_CAL, 8'h3C);
    rchk(awg_pkg::IDX_OSC_OVR_EN, 8'h08);
    rchk(10'h001, 8'h00);
    // filter calibration on idle-to-ready, then skipped with code 3
    for (int s = 0; s < 2; s++) begin
      @(posedge hclk);
      phy_ready_entry <= 1'b1;
      @(posedge hclk);
      phy_ready_entry <= 1'b0;
      @(posedge hclk);
      `CHK("filter_cal_start", s == 0, filter_cal_start)
      xfer(1'b1, awg_pkg::IDX_FILTER_CAL, 8'h3F);
    end
    // aux power: software bits, controller bits, pa hand-over
    rc_aux_hi <= 1'b1;
    rc_aux_lo <= 4'hA;
    xfer(1'b1, awg_pkg::IDX_AUX_POWER, 8'h30);
    settle;
    `CHK("battery_monitor_en", 1'b1, battery_monitor_en)
    `CHK("extpa_bias_en", 1'b1, extpa_bias_en)
    rchk(awg_pkg::IDX_AUX_POWER, 8'h7A);
    xfer(1'b1, awg_pkg::IDX_EXT_CTRL, 8'h04);
    settle;
    `CHK("extpa_bias_en", 1'b0, extpa_bias_en)
    // wake flags: set by events, kept over reads, cleared by flag reset
    slow_crystal_settled <= 1'b1;
    xfer(1'b1, awg_pkg::IDX_SLEEP_CFG, 8'h20);
    timer_timeout <= 1'b1;
    cold_start    <= 1'b1;
    @(posedge hclk);
    timer_timeout <= 1'b0;
    cold_start    <= 1'b0;
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h16);
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h16);
    xfer(1'b1, awg_pkg::IDX_TIMER_CTRL, 8'h01);
    xfer(1'b1, awg_pkg::IDX_TIMER_CTRL, 8'h00);
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h10);
    xfer(1'b1, awg_pkg::IDX_SLEEP_CFG, 8'h08);
    // slow calibration busy, then done after the run time
    xfer(1'b1, awg_pkg::IDX_TIMER_CTRL, 8'h02);
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h00);
    repeat (8) @(posedge hclk);
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h00);
    repeat (14) @(posedge hclk);
    rchk(awg_pkg::IDX_WAKE_STATUS, 8'h20);
    `CHK("lf_cal_req", 1'b1, lf_calibration_request)
    // pin modes: interrupt with automation, gpio, serial, symbol, reserved
    rc_rxen <= 1'b1;
    rc_txen <= 1'b1;
    interrupt_out_one_req <= 1'b1;
    xfer(1'b1, awg_pkg::IDX_EXT_CTRL, 8'h03);
    settle;
    `CHK("gpio_out", 8'h61, gpio_out & 8'h63)
    xfer(1'b1, awg_pkg::IDX_EXT_CTRL, 8'h00);
    xfer(1'b1, awg_pkg::IDX_PIN_OUT, 8'hA5);
    xfer(1'b1, awg_pkg::IDX_PIN_FUNC, 8'h04);
    tx_active    <= 1'b1;
    sport_clk_in <= 1'b1;
    settle;
    `CHK("gpio_out", 8'hA5, gpio_out)
    `CHK("serial_port_clock_pin", 1'b1, serial_port_clock_pin)
    xfer(1'b1, awg_pkg::IDX_PIN_FUNC, 8'h01);
    tx_active <= 1'b0;
    rx_active <= 1'b1;
    settle;
    `CHK("serial_port_clock_oe", 1'b0, serial_port_clock_oe)
    sync_word_detected <= 1'b1;
    settle;
    `CHK("serial_port_clock_oe", 1'b1, serial_port_clock_oe)
    symbol_data_in <= 4'hB;
    xfer(1'b1, awg_pkg::IDX_PIN_FUNC, 8'h07);
    settle;
    `CHK("gpio_out", 8'h43, gpio_out & 8'h63)
    xfer(1'b1, awg_pkg::IDX_PIN_FUNC, 8'h02);
    settle;
    `CHK("gpio_oe", 8'h00, gpio_oe)
    // oscillator overrides need the skip code and their enables
    xfer(1'b1, awg_pkg::IDX_OSC_CURR, 8'hC3);
    xfer(1'b1, awg_pkg::IDX_OSC_OVR_EN, 8'h0B);
    settle;
    `CHK("osc_apply", 2'b00, {osc_current_apply, osc_band_apply})
    xfer(1'b1, awg_pkg::IDX_OSC_CAL_CFG, 8'h0F);
    xfer(1'b1, awg_pkg::IDX_OSC_OVR_EN, 8'h0A);
    settle;
    `CHK("osc_apply", 2'b10, {osc_current_apply, osc_band_apply})
    `CHK("osc_current_value", 8'hC3, osc_current_value)
    conclude;
  end
endmodule
bind awg_aux_regs awg_aux_sva awg_aux_sva_i (.*);
